// ---- core/rae_pkg.sv ----
package rae_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PRIO_EXT = 8'h04;
  localparam logic [7:0] OFF_PRIO_PER = 8'h08;
  localparam logic [7:0] OFF_VBR = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_FAULT = 8'h14;
  // Field positions and reset values.
  localparam int CTRL_SINGLE_CHIP = 0;
  localparam int SR_MASK_LSB = 4;
  localparam logic [31:0] SR_RST = 32'h0000_00F0;
  localparam logic [31:0] PRIO_RST = 32'h0000_0000;
  localparam logic [3:0] MASK_ALL = 4'hF;
  localparam logic [3:0] LVL_UB = 4'hF;
  localparam logic [3:0] LVL_NMI_MASK = 4'hF;
  // Minimum reset hold in clock cycles.
  localparam logic [4:0] RST_MIN_CYC = 5'h14;
  // Reset vector addresses.
  localparam logic [31:0] VEC_COLD_PC = 32'h0000_0000;
  localparam logic [31:0] VEC_WARM_PC = 32'h0000_0008;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  // Exception vector numbers.
  localparam logic [7:0] VECN_CPU_AE = 8'h09;
  localparam logic [7:0] VECN_DMA_AE = 8'h0A;
  localparam logic [7:0] VECN_NMI = 8'h0B;
  localparam logic [7:0] VECN_UB = 8'h0C;
  localparam logic [7:0] VECN_EXT = 8'h40;
  localparam logic [7:0] VECN_PER = 8'h48;
  // Address map: peripheral window, its 8-bit half, external space.
  localparam logic [31:0] PER_LO = 32'hFFFF_8000;
  localparam logic [31:0] PER8_LO = 32'hFFFF_C000;
  localparam logic [31:0] EXT_LO = 32'h0040_0000;
  localparam logic [31:0] EXT_HI = 32'hFFFF_7FFF;
  localparam int NSRC = 8;

  typedef enum logic [1:0] {
    RAE_SZ_BYTE = 2'b00,
    RAE_SZ_WORD = 2'b01,
    RAE_SZ_LONG = 2'b10
  } rae_size_e;

  typedef enum logic [1:0] {
    RAE_M_CPU = 2'b00,
    RAE_M_DMA = 2'b01,
    RAE_M_XFER = 2'b10
  } rae_master_e;

  typedef enum logic [2:0] {
    RAE_RUN = 3'b000,
    RAE_RST_HOLD = 3'b001,
    RAE_RST_PC = 3'b010,
    RAE_RST_SP = 3'b011,
    RAE_PUSH_SR = 3'b100,
    RAE_PUSH_PC = 3'b101,
    RAE_VEC = 3'b110
  } rae_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } rae_apb_s;

  typedef struct packed {
    logic vld;
    logic [31:0] addr;
    rae_size_e size;
    rae_master_e master;
  } rae_acc_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rae_mem_s;
endpackage

// ---- core/rae_sync.sv ----
// Two-flop synchroniser for asynchronous pins.
module rae_sync #(
  parameter int W = 11,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i, // Core clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic [W-1:0] d_i, // Asynchronous pin levels.
  output logic [W-1:0] q_o // Synchronised levels.
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
  } rae_sync_s;

  rae_sync_s s;
  rae_sync_s next_s;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_s.ff1 = d_i;
    next_s.ff2 = s.ff1;
  end

  // Both stages take the idle level under reset.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s <= {RST_VAL, RST_VAL};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign q_o = s.ff2;
endmodule

// ---- core/rae_addr_chk.sv ----
// Combinational address error classification.
module rae_addr_chk (
  input wire logic fetch_vld_i, // Instruction fetch this cycle.
  input wire logic [31:0] fetch_addr_i, // Fetch address.
  input rae_pkg::rae_acc_s dacc_i, // Data access by any master.
  input wire logic single_chip_i, // Single-chip operation.
  output logic fetch_err_o, // Fetch faults.
  output logic data_err_o // Data access faults.
);
  logic f_per;
  logic f_ext;
  logic d_per;
  logic d_per8;
  logic d_ext;
  logic mis_word;
  logic mis_long;

  // Region decode for both address streams.
  always_comb
  begin
    f_per = fetch_addr_i >= rae_pkg::PER_LO;
    f_ext = (fetch_addr_i >= rae_pkg::EXT_LO) && (fetch_addr_i <= rae_pkg::EXT_HI);
    d_per = dacc_i.addr >= rae_pkg::PER_LO;
    d_per8 = dacc_i.addr >= rae_pkg::PER8_LO;
    d_ext = (dacc_i.addr >= rae_pkg::EXT_LO) && (dacc_i.addr <= rae_pkg::EXT_HI);
    mis_word = (dacc_i.size == rae_pkg::RAE_SZ_WORD) && dacc_i.addr[0];
    mis_long = (dacc_i.size == rae_pkg::RAE_SZ_LONG) && (dacc_i.addr[1:0] != 2'h0);
  end

  // Fetch faults: odd address, peripheral space, barred external space.
  assign fetch_err_o = fetch_vld_i && (fetch_addr_i[0] || f_per || (single_chip_i && f_ext));

  // Data faults: misalignment, longword into 8-bit peripherals, barred external.
  assign data_err_o = dacc_i.vld && (mis_word || mis_long
    || ((dacc_i.size == rae_pkg::RAE_SZ_LONG) && d_per && d_per8)
    || (single_chip_i && d_ext));
endmodule

// ---- core/rae_top.sv ----
// Reset sequencing, address error detection and interrupt priority front end.
//
// The APB register port and the register addresses were chosen for this implementation.
module rae_top (
  input wire logic clk_i, // Core clock, 100 MHz.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input rae_pkg::rae_apb_s apb_i, // APB request.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error on unmapped address.
  input wire logic cold_init_pin_n_i, // Cold reset pin, active low.
  input wire logic warm_init_pin_n_i, // Warm reset pin, active low.
  input wire logic nmi_pin_i, // Nonmaskable interrupt pin.
  input wire logic [7:0] ext_int_lines_i, // External interrupt lines.
  input wire logic user_break_req_i, // User break request.
  input wire logic [7:0] periph_int_req_i, // Peripheral requests.
  input wire logic bus_busy_i, // A bus cycle is in progress.
  input wire logic instr_done_i, // Instruction boundary.
  input wire logic [31:0] next_pc_i, // Address after last instruction.
  input wire logic sr_wr_i, // CPU writes the status word.
  input wire logic [31:0] sr_wdata_i, // Status word from CPU.
  input wire logic fetch_vld_i, // Instruction fetch.
  input wire logic [31:0] fetch_addr_i, // Fetch address.
  input rae_pkg::rae_acc_s dacc_i, // Data access.
  output rae_pkg::rae_mem_s mem_o, // Vector and stack access.
  input wire logic mem_ack_i, // Memory access done.
  input wire logic [31:0] mem_rdata_i, // Memory read data.
  output logic [31:0] pc_o, // Program counter to load.
  output logic pc_load_o, // Jump strobe.
  output logic [31:0] sp_o, // Stack pointer.
  output logic [31:0] status_word_o, // Status word.
  output logic [31:0] vector_base_reg_o, // Vector base.
  output logic cpu_init_o, // CPU held initialised.
  output logic periph_init_o, // Peripherals held initialised.
  output logic bus_ctl_init_o // Bus state unit held initialised.
);
  typedef struct packed {
    rae_pkg::rae_state_e st;
    logic [4:0] rcnt;
    logic cold;
    logic [31:0] sr;
    logic [31:0] vector_base_reg;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [31:0] ret_pc;
    logic [31:0] fault;
    logic [7:0] vec;
    logic ae_cpu;
    logic ae_dma;
    logic nmi_pend;
    logic nmi_prev;
    logic single_chip;
    logic [31:0] prio_ext;
    logic [31:0] prio_per;
    rae_pkg::rae_mem_s mem;
    logic pc_load;
    logic cpu_init;
    logic periph_init;
    logic bsc_init;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rae_state_s;

  rae_state_s s;
  rae_state_s next_s;
  logic [10:0] pins;
  logic cold_n;
  logic warm_n;
  logic nmi;
  logic [7:0] ext;
  logic fetch_err;
  logic data_err;
  logic [3:0] lvl [2*rae_pkg::NSRC];
  logic [2*rae_pkg::NSRC-1:0] req;
  logic [3:0] best_lvl;
  logic [7:0] best_vec;
  logic best_vld;
  logic [3:0] mask;
  logic [7:0] roff;
  logic unmapped;
  logic [31:0] rd;

  // Pins cross into the clock domain; reset pins idle high.
  rae_sync #(
    .W(11),
    .RST_VAL(11'h600)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({cold_init_pin_n_i, warm_init_pin_n_i, nmi_pin_i, ext_int_lines_i}),
    .q_o(pins)
  );

  assign cold_n = pins[10];
  assign warm_n = pins[9];
  assign nmi = pins[8];
  assign ext = pins[7:0];

  rae_addr_chk u_chk (
    .fetch_vld_i(fetch_vld_i),
    .fetch_addr_i(fetch_addr_i),
    .dacc_i(dacc_i),
    .single_chip_i(s.single_chip),
    .fetch_err_o(fetch_err),
    .data_err_o(data_err)
  );

  // Per-source request and programmed level; a 4-bit field cannot hold 16.
  for (genvar i = 0; i < rae_pkg::NSRC; i++)
  begin : g_src
    assign req[i] = ext[i];
    assign req[rae_pkg::NSRC + i] = periph_int_req_i[i];
    assign lvl[i] = s.prio_ext[4*i +: 4];
    assign lvl[rae_pkg::NSRC + i] = s.prio_per[4*i +: 4];
  end

  assign mask = s.sr[rae_pkg::SR_MASK_LSB +: 4];

  // Highest requesting level; the lowest index wins a tie.
  always_comb
  begin
    best_lvl = 4'h0;
    best_vec = 8'h00;
    best_vld = 1'b0;
    for (int i = 0; i < 2 * rae_pkg::NSRC; i++)
    begin
      if (req[i] && (lvl[i] > mask) && (!best_vld || (lvl[i] > best_lvl)))
      begin
        best_vld = 1'b1;
        best_lvl = lvl[i];
        best_vec = rae_pkg::VECN_EXT + 8'(i);
      end
    end
  end

  // Register read decode.
  always_comb
  begin
    roff = apb_i.paddr[7:0];
    unmapped = (apb_i.paddr[31:8] != 24'h00_0000) || (roff[1:0] != 2'h0) || (roff > rae_pkg::OFF_FAULT);
    case (roff)
      rae_pkg::OFF_CTRL: rd = {31'h0000_0000, s.single_chip};
      rae_pkg::OFF_PRIO_EXT: rd = s.prio_ext;
      rae_pkg::OFF_PRIO_PER: rd = s.prio_per;
      rae_pkg::OFF_VBR: rd = s.vector_base_reg;
      rae_pkg::OFF_STATUS: rd = {20'h0_0000, s.nmi_pend, s.ae_dma, s.ae_cpu, 2'h0, s.st, mask};
      rae_pkg::OFF_FAULT: rd = s.fault;
      default: rd = 32'h0000_0000;
    endcase
  end

  // Next state of the whole block.
  always_comb
  begin
    next_s = s;
    next_s.pc_load = 1'b0;
    next_s.nmi_prev = nmi;
    // APB: setup cycle prepares the answer, first access edge completes.
    next_s.pready = apb_i.psel && !apb_i.penable;
    next_s.pslverr = apb_i.psel && !apb_i.penable && unmapped;
    next_s.prdata = (apb_i.psel && !apb_i.penable && !apb_i.pwrite) ? rd : 32'h0000_0000;
    if (apb_i.psel && apb_i.penable && s.pready && apb_i.pwrite && !s.pslverr)
    begin
      case (apb_i.paddr[7:0])
        rae_pkg::OFF_CTRL: next_s.single_chip = apb_i.pwdata[rae_pkg::CTRL_SINGLE_CHIP];
        rae_pkg::OFF_PRIO_EXT: next_s.prio_ext = apb_i.pwdata;
        rae_pkg::OFF_PRIO_PER: next_s.prio_per = apb_i.pwdata;
        rae_pkg::OFF_VBR: next_s.vector_base_reg = apb_i.pwdata;
        default: next_s.prio_per = s.prio_per;
      endcase
    end
    if (sr_wr_i && (s.st == rae_pkg::RAE_RUN))
    begin
      next_s.sr = sr_wdata_i;
    end

    // Exception sequencer.
    case (s.st)
      rae_pkg::RAE_RUN:
      begin
        next_s.rcnt = 5'h00;
        if (instr_done_i)
        begin
          if (s.ae_cpu || s.ae_dma || s.nmi_pend
            || (user_break_req_i && (rae_pkg::LVL_UB > mask)) || best_vld)
          begin
            next_s.st = rae_pkg::RAE_PUSH_SR;
            next_s.ret_pc = next_pc_i;
            next_s.mem = '{req: 1'b1, we: 1'b1, addr: s.sp - rae_pkg::WORD_STEP, wdata: s.sr};
            next_s.sp = s.sp - rae_pkg::WORD_STEP;
          end
          // One source per entry, the rest stay pending.
          if (s.ae_cpu)
          begin
            next_s.vec = rae_pkg::VECN_CPU_AE;
            next_s.ae_cpu = 1'b0;
          end
          else if (s.ae_dma)
          begin
            next_s.vec = rae_pkg::VECN_DMA_AE;
            next_s.ae_dma = 1'b0;
          end
          else if (s.nmi_pend)
          begin
            next_s.vec = rae_pkg::VECN_NMI;
            next_s.nmi_pend = 1'b0;
            next_s.sr[rae_pkg::SR_MASK_LSB +: 4] = rae_pkg::LVL_NMI_MASK;
          end
          else if (user_break_req_i && (rae_pkg::LVL_UB > mask))
          begin
            next_s.vec = rae_pkg::VECN_UB;
            next_s.sr[rae_pkg::SR_MASK_LSB +: 4] = rae_pkg::LVL_UB;
          end
          else if (best_vld)
          begin
            next_s.vec = best_vec;
            next_s.sr[rae_pkg::SR_MASK_LSB +: 4] = best_lvl;
          end
        end
      end
      rae_pkg::RAE_PUSH_SR:
      begin
        if (mem_ack_i)
        begin
          next_s.st = rae_pkg::RAE_PUSH_PC;
          next_s.mem = '{req: 1'b1, we: 1'b1, addr: s.sp - rae_pkg::WORD_STEP, wdata: s.ret_pc};
          next_s.sp = s.sp - rae_pkg::WORD_STEP;
        end
      end
      rae_pkg::RAE_PUSH_PC:
      begin
        if (mem_ack_i)
        begin
          next_s.st = rae_pkg::RAE_VEC;
          next_s.mem = '{req: 1'b1, we: 1'b0, addr: s.vector_base_reg + {22'h00_0000, s.vec, 2'h0}, wdata: 32'h0000_0000};
        end
      end
      rae_pkg::RAE_VEC:
      begin
        if (mem_ack_i)
        begin
          // The handler runs next; nothing in a delay slot executes.
          next_s.st = rae_pkg::RAE_RUN;
          next_s.pc = mem_rdata_i;
          next_s.pc_load = 1'b1;
          next_s.mem = '0;
        end
      end
      rae_pkg::RAE_RST_HOLD:
      begin
        if (s.rcnt != 5'h1F)
        begin
          next_s.rcnt = s.rcnt + 5'h01;
        end
      end
      rae_pkg::RAE_RST_PC:
      begin
        if (mem_ack_i)
        begin
          next_s.st = rae_pkg::RAE_RST_SP;
          next_s.pc = mem_rdata_i;
          next_s.mem.addr = s.mem.addr + rae_pkg::WORD_STEP;
        end
      end
      rae_pkg::RAE_RST_SP:
      begin
        if (mem_ack_i)
        begin
          next_s.st = rae_pkg::RAE_RUN;
          next_s.sp = mem_rdata_i;
          next_s.vector_base_reg = 32'h0000_0000;
          next_s.sr[rae_pkg::SR_MASK_LSB +: 4] = rae_pkg::MASK_ALL;
          next_s.pc_load = 1'b1;
          next_s.cpu_init = 1'b0;
          next_s.mem = '0;
        end
      end
      default:
      begin
        next_s.st = rae_pkg::RAE_RST_HOLD;
      end
    endcase

    // New faults and NMI edges are added after the sequencer's clears, so a set wins over an entry.
    if (fetch_err || (data_err && (dacc_i.master == rae_pkg::RAE_M_CPU)))
    begin
      next_s.ae_cpu = 1'b1;
    end
    if (data_err && (dacc_i.master != rae_pkg::RAE_M_CPU))
    begin
      next_s.ae_dma = 1'b1;
    end
    if ((fetch_err || data_err) && !(s.ae_cpu || s.ae_dma))
    begin
      next_s.fault = fetch_err ? fetch_addr_i : dacc_i.addr;
    end
    if (nmi && !s.nmi_prev)
    begin
      next_s.nmi_pend = 1'b1;
    end

    // Reset hold and release; resets override the state and pending flags set above.
    if (!cold_n)
    begin
      next_s.st = rae_pkg::RAE_RST_HOLD;
      next_s.rcnt = (s.st == rae_pkg::RAE_RST_HOLD && s.rcnt != 5'h1F) ? s.rcnt + 5'h01 : s.rcnt;
      next_s.cold = 1'b1;
      next_s.cpu_init = 1'b1;
      next_s.periph_init = 1'b1;
      next_s.bsc_init = 1'b1;
      next_s.single_chip = 1'b0;
      next_s.prio_ext = rae_pkg::PRIO_RST;
      next_s.prio_per = rae_pkg::PRIO_RST;
    end
    else if (!warm_n && (s.st == rae_pkg::RAE_RST_HOLD || !bus_busy_i))
    begin
      next_s.st = rae_pkg::RAE_RST_HOLD;
      next_s.cold = s.st == rae_pkg::RAE_RST_HOLD ? s.cold : 1'b0;
      next_s.cpu_init = 1'b1;
      next_s.periph_init = 1'b0;
      next_s.bsc_init = 1'b0;
    end
    else if (s.st == rae_pkg::RAE_RST_HOLD)
    begin
      next_s.periph_init = 1'b0;
      next_s.bsc_init = 1'b0;
      next_s.rcnt = 5'h00;
      // A pulse shorter than the minimum leaves the CPU held.
      if (s.rcnt >= rae_pkg::RST_MIN_CYC - 5'h01)
      begin
        next_s.st = rae_pkg::RAE_RST_PC;
        next_s.mem = '{req: 1'b1, we: 1'b0, addr: s.cold ? rae_pkg::VEC_COLD_PC : rae_pkg::VEC_WARM_PC,
          wdata: 32'h0000_0000};
      end
    end
    if (s.st == rae_pkg::RAE_RST_HOLD || !cold_n || next_s.st == rae_pkg::RAE_RST_HOLD)
    begin
      next_s.ae_cpu = 1'b0;
      next_s.ae_dma = 1'b0;
      next_s.nmi_pend = 1'b0;
      next_s.mem = (next_s.st == rae_pkg::RAE_RST_HOLD) ? '0 : next_s.mem;
    end

    // System reset behaves as a cold reset held long enough.
    if (!rst_n_i)
    begin
      next_s = '0;
      next_s.st = rae_pkg::RAE_RST_HOLD;
      next_s.rcnt = rae_pkg::RST_MIN_CYC;
      next_s.cold = 1'b1;
      next_s.sr = rae_pkg::SR_RST;
      next_s.nmi_prev = 1'b1;
      next_s.cpu_init = 1'b1;
      next_s.periph_init = 1'b1;
      next_s.bsc_init = 1'b1;
    end
  end

  // All state is registered on every edge.
  always_ff @(posedge clk_i)
  begin
    s <= next_s;
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign mem_o = s.mem;
  assign pc_o = s.pc;
  assign pc_load_o = s.pc_load;
  assign sp_o = s.sp;
  assign status_word_o = s.sr;
  assign vector_base_reg_o = s.vector_base_reg;
  assign cpu_init_o = s.cpu_init;
  assign periph_init_o = s.periph_init;
  assign bus_ctl_init_o = s.bsc_init;
endmodule

// ---- dv/rae_mem_model.sv ----
// Memory on the far side of the vector and stack port.
module rae_mem_model (
  input wire logic clk_i, // Core clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input rae_pkg::rae_mem_s mem_i, // Request from the block.
  input wire logic [3:0] dly_i, // Wait cycles before each answer.
  output logic ack_o, // One-cycle completion.
  output logic [31:0] rdata_o, // Read data, scrambled while idle.
  output logic [31:0] wa_o, // Address of the last write.
  output logic [31:0] wd_o // Data of the last write.
);
  logic [3:0] cnt;

  // Answers after dly_i waits with the address plus 0x1000; idle data toggles.
  always_ff @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (!rst_n_i)
    begin
      cnt <= 4'h0;
      rdata_o <= 32'h0000_0000;
    end
    else if (mem_i.req && !ack_o)
    begin
      if (cnt == dly_i)
      begin
        cnt <= 4'h0;
        ack_o <= 1'b1;
        rdata_o <= mem_i.addr + 32'h0000_1000;
        if (mem_i.we)
        begin
          wa_o <= mem_i.addr;
          wd_o <= mem_i.wdata;
        end
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule

// ---- dv/rae_top_sva.sv ----
// Timing checks on the ports of the exception front end.
module rae_top_chk (
  input wire logic clk_i, // Core clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input rae_pkg::rae_apb_s apb_i, // APB request.
  input wire logic pready_o, // APB ready.
  input wire logic cold_init_pin_n_i, // Cold reset pin.
  input wire logic bus_busy_i, // Bus cycle in progress.
  input wire logic instr_done_i, // Instruction boundary.
  input rae_pkg::rae_mem_s mem_o, // Vector and stack access.
  input wire logic mem_ack_i, // Memory access done.
  input wire logic [31:0] mem_rdata_i, // Memory read data.
  input wire logic [31:0] pc_o, // Program counter to load.
  input wire logic pc_load_o, // Jump strobe.
  input wire logic [31:0] sp_o, // Stack pointer.
  input wire logic [31:0] status_word_o, // Status word.
  input wire logic [31:0] vector_base_reg_o, // Vector base.
  input wire logic cpu_init_o, // CPU held initialised.
  input wire logic periph_init_o, // Peripherals initialised.
  input wire logic bus_ctl_init_o // Bus state unit initialised.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Transfer steps.
  sequence apb_setup;
    apb_i.psel && !apb_i.penable;
  endsequence
  sequence boot_sp_ack;
    cpu_init_o && mem_o.req && mem_ack_i && mem_o.addr[2];
  endsequence
  sequence vec_ack;
    !cpu_init_o && mem_o.req && !mem_o.we && mem_ack_i;
  endsequence

  apb_ready_a:
    assert property (apb_setup |=> pready_o) else $error("no ready after setup");
  cold_hold_a:
    assert property (!cold_init_pin_n_i [*5] |-> cpu_init_o && periph_init_o && bus_ctl_init_o && !mem_o.req)
    else $error("cold reset not applied");
  warm_spare_a:
    assert property (cold_init_pin_n_i [*5] |-> !periph_init_o && !bus_ctl_init_o)
    else $error("peripherals reset without cold pin");
  vec_addr_a:
    assert property (cpu_init_o && mem_o.req |-> !mem_o.we && mem_o.addr inside {32'h0000_0000, 32'h0000_0004,
                     32'h0000_0008, 32'h0000_000C}) else $error("bad reset vector access");
  boot_load_a:
    assert property (boot_sp_ack |=> pc_load_o && !cpu_init_o && sp_o == $past(mem_rdata_i) &&
                     vector_base_reg_o == 32'h0000_0000 && status_word_o[7:4] == 4'hF) else $error("bad reset load");
  warm_wait_a:
    assert property (cold_init_pin_n_i [*5] ##0 (bus_busy_i && !cpu_init_o) |=> !cpu_init_o)
    else $error("reset entered during bus cycle");
  entry_bound_a:
    assert property (!instr_done_i && !mem_o.req && !cpu_init_o |=> !mem_o.req)
    else $error("exception entered off instruction boundary");
  handler_jump_a:
    assert property (vec_ack |=> pc_load_o && pc_o == $past(mem_rdata_i)) else $error("handler jump late or wrong");
endmodule

bind rae_top rae_top_chk u_sva (.clk_i, .rst_n_i, .apb_i, .pready_o, .cold_init_pin_n_i, .bus_busy_i,
  .instr_done_i, .mem_o, .mem_ack_i, .mem_rdata_i, .pc_o, .pc_load_o, .sp_o, .status_word_o, .vector_base_reg_o,
  .cpu_init_o, .periph_init_o, .bus_ctl_init_o);

// ---- dv/tb_top.sv ----
// Self-checking bench for the exception front end.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic f;
    logic sc;
    logic [31:0] a;
    logic [1:0] sz;
    logic [1:0] m;
    logic [1:0] fl;
  } rae_row_s;
  logic clk_i, rst_n_i, pready, pslverr, cold_n, warm_n, nmi, ub, busy, idone, sr_wr, fv, ack, pc_ld;
  logic cpu_init, per_init, bus_init;
  logic [7:0] ext, per;
  logic [3:0] dly;
  logic [31:0] prdata, npc, sr_wd, fa, rdata, pc, sp, sw, vector_base_reg, wa, wd, exp_sp;
  rae_pkg::rae_apb_s apb;
  rae_pkg::rae_acc_s dacc;
  rae_pkg::rae_mem_s mem;
  int n_fail, checked, cyc;
  // Fetch flag, single-chip, address, size, master, expected fault flags.
  rae_row_s rows [12] = '{
    '{1'h1, 1'h0, 32'h0000_1002, 2'h0, 2'h0, 2'h0}, '{1'h1, 1'h0, 32'h0000_1001, 2'h0, 2'h0, 2'h1},
    '{1'h1, 1'h0, 32'hFFFF_8000, 2'h0, 2'h0, 2'h1}, '{1'h1, 1'h1, 32'h0040_0000, 2'h0, 2'h0, 2'h1},
    '{1'h1, 1'h0, 32'h0040_0000, 2'h0, 2'h0, 2'h0}, '{1'h0, 1'h0, 32'h0000_2001, 2'h1, 2'h0, 2'h1},
    '{1'h0, 1'h0, 32'h0000_2002, 2'h2, 2'h1, 2'h2}, '{1'h0, 1'h0, 32'h0000_2004, 2'h2, 2'h2, 2'h0},
    '{1'h0, 1'h0, 32'hFFFF_C000, 2'h2, 2'h0, 2'h1}, '{1'h0, 1'h0, 32'hFFFF_8000, 2'h2, 2'h0, 2'h0},
    '{1'h0, 1'h0, 32'hFFFF_C001, 2'h0, 2'h1, 2'h0}, '{1'h0, 1'h1, 32'h0040_0000, 2'h0, 2'h2, 2'h2}};

  rae_top u_rae_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cold_init_pin_n_i(cold_n), .warm_init_pin_n_i(warm_n), .nmi_pin_i(nmi),
    .ext_int_lines_i(ext), .user_break_req_i(ub), .periph_int_req_i(per), .bus_busy_i(busy), .instr_done_i(idone),
    .next_pc_i(npc), .sr_wr_i(sr_wr), .sr_wdata_i(sr_wd), .fetch_vld_i(fv), .fetch_addr_i(fa), .dacc_i(dacc),
    .mem_o(mem), .mem_ack_i(ack), .mem_rdata_i(rdata), .pc_o(pc), .pc_load_o(pc_ld), .sp_o(sp),
    .status_word_o(sw), .vector_base_reg_o(vector_base_reg), .cpu_init_o(cpu_init), .periph_init_o(per_init),
    .bus_ctl_init_o(bus_init));
  rae_mem_model u_rae_mem_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_i(mem), .dly_i(dly), .ack_o(ack),
    .rdata_o(rdata), .wa_o(wa), .wd_o(wd));

  // Compares a value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer, held until ready.
  task automatic apb_x(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
    @(posedge clk_i);
    apb <= '{1'b1, 1'b0, w, {24'h00_0000, a}, d};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    do
      @(posedge clk_i);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    apb <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_x(1'b1, a, d, r, e);
  endtask
  task automatic wait_pc();
    do
      @(posedge clk_i);
    while (pc_ld !== 1'b1);
  endtask
  // Ends an instruction and checks stacking and jump.
  task automatic ent_chk(input logic [31:0] ret, input logic [7:0] vec);
    @(posedge clk_i);
    npc <= ret;
    idone <= 1'b1;
    @(posedge clk_i);
    idone <= 1'b0;
    wait_pc();
    chk(pc, {22'h00_0000, vec, 2'h0} + 32'h0000_1000);
    chk(wa, exp_sp - 32'h0000_0008);
    chk(wd, ret);
    exp_sp = exp_sp - 32'h0000_0008;
  endtask
  // Raises sources under a mask; vec zero means no entry.
  task automatic irq(input logic [3:0] msk, input logic [7:0] e8, input logic [7:0] p8, input logic u,
                     input logic n, input logic [7:0] vec, input logic [3:0] nm);
    @(posedge clk_i);
    sr_wr <= 1'b1;
    sr_wd <= {24'h00_0000, msk, 4'h0};
    @(posedge clk_i);
    sr_wr <= 1'b0;
    ext <= e8;
    per <= p8;
    ub <= u;
    nmi <= n;
    repeat (4) @(posedge clk_i);
    if (vec == 8'h00)
    begin
      idone <= 1'b1;
      @(posedge clk_i);
      idone <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk(32'(mem.req), 32'h0000_0000);
    end
    else
    begin
      ent_chk(32'h0000_4000, vec);
      chk(32'(sw[7:4]), 32'(nm));
    end
    {ext, per, ub, nmi} <= '0;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Cuts a hung run short.
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    {rst_n_i, nmi, ub, busy, idone, sr_wr, fv, ext, per, dly} = '0;
    {cold_n, warm_n} = 2'h3;
    {npc, sr_wd, fa} = '0;
    apb = '0;
    dacc = '0;
    {n_fail, checked, cyc} = '0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_pc();
    chk(pc, 32'h0000_1000);
    chk(sp, 32'h0000_1004);
    chk({vector_base_reg[27:0], sw[7:4]}, 32'h0000_000F);
    exp_sp = 32'h0000_1004;
    apb_x(1'b0, 8'h18, 32'h0000_0000, r, e);
    chk(32'(e), 32'h0000_0001);
    $display("test boot done");
    foreach (rows[k])
    begin
      wr(rae_pkg::OFF_CTRL, 32'(rows[k].sc));
      @(posedge clk_i);
      fv <= rows[k].f;
      fa <= rows[k].a;
      dacc <= '{!rows[k].f, rows[k].a, rae_pkg::rae_size_e'(rows[k].sz), rae_pkg::rae_master_e'(rows[k].m)};
      @(posedge clk_i);
      fv <= 1'b0;
      dacc.vld <= 1'b0;
      apb_x(1'b0, rae_pkg::OFF_STATUS, 32'h0000_0000, r, e);
      chk(32'(r[10:9]), 32'(rows[k].fl));
      if (rows[k].fl != 2'h0)
        ent_chk(32'h0000_3000 + 32'(k), rows[k].fl == 2'h1 ? 8'h09 : 8'h0A);
    end
    $display("test address errors done");
    wr(rae_pkg::OFF_PRIO_EXT, 32'h7777_7777);
    wr(rae_pkg::OFF_PRIO_PER, 32'h7777_7777);
    for (int j = 0; j < 8; j++)
    begin
      irq(4'h6, 8'h01 << j, 8'h00, 1'b0, 1'b0, 8'h40 + 8'(j), 4'h7);
      irq(4'h6, 8'h00, 8'h01 << j, 1'b0, 1'b0, 8'h48 + 8'(j), 4'h7);
    end
    wr(rae_pkg::OFF_PRIO_EXT, 32'h0500_5000);
    wr(rae_pkg::OFF_PRIO_PER, 32'h0000_0900);
    dly <= 4'h2;
    irq(4'h4, 8'h48, 8'h04, 1'b0, 1'b0, 8'h4A, 4'h9);
    irq(4'h5, 8'h48, 8'h00, 1'b0, 1'b0, 8'h00, 4'h0);
    irq(4'h4, 8'h48, 8'h00, 1'b0, 1'b0, 8'h43, 4'h5);
    irq(4'hE, 8'h00, 8'h00, 1'b1, 1'b0, 8'h0C, 4'hF);
    irq(4'hF, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 4'h0);
    irq(4'hF, 8'h48, 8'h00, 1'b1, 1'b1, 8'h0B, 4'hF);
    $display("test interrupts done");
    wr(rae_pkg::OFF_VBR, 32'h0000_0100);
    wr(rae_pkg::OFF_PRIO_PER, 32'h0000_0A00);
    busy <= 1'b1;
    warm_n <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk(32'(cpu_init), 32'h0000_0000);
    busy <= 1'b0;
    repeat (25) @(posedge clk_i);
    chk(32'({cpu_init, per_init, bus_init}), 32'h0000_0004);
    apb_x(1'b0, rae_pkg::OFF_PRIO_PER, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0A00);
    warm_n <= 1'b1;
    wait_pc();
    chk(pc, 32'h0000_1008);
    chk(sp, 32'h0000_100C);
    chk({vector_base_reg[27:0], sw[7:4]}, 32'h0000_000F);
    $display("test warm reset done");
    cold_n <= 1'b0;
    nmi <= 1'b1;
    idone <= 1'b1;
    repeat (25) @(posedge clk_i);
    chk(32'({cpu_init, per_init, bus_init}), 32'h0000_0007);
    chk(32'(mem.req), 32'h0000_0000);
    apb_x(1'b0, rae_pkg::OFF_PRIO_PER, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    {nmi, idone, cold_n} <= 3'h1;
    wait_pc();
    chk(pc, 32'h0000_1000);
    chk(sp, 32'h0000_1004);
    $display("test cold reset done");
    stop_test();
  end
endmodule
